// file: rtl/eepc_cells.sv
// Nonvolatile array and setup cell with registered read
`timescale 1ns/100ps
module eepc_cells import eepc_pkg::*; #(
	parameter int DEPTH = EEPC_ARR_BYTES
) (
	input wire logic core_clk,
	input wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic [7:0] rd_data,
	input wire logic wr_en,
	input wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input wire logic wr_erase,
	input wire logic [7:0] wr_data,
	input wire logic setup_we,
	input wire logic setup_erase,
	input wire logic [7:0] setup_data,
	output logic [7:0] setup_cell
);
	// Cells start erased; they keep their contents across reset
	logic [7:0] mem [DEPTH] = '{default: EEPC_ERASED};
	logic [7:0] setup_q = EEPC_ERASED;

	assign setup_cell = setup_q;

	// Programming only clears bits; erase sets all ones
	always_ff @(posedge core_clk) begin
		rd_data <= mem[rd_addr];
		if (wr_en)
			mem[wr_addr] <= wr_erase ? EEPC_ERASED : (mem[wr_addr] & wr_data);
		if (setup_we)
			setup_q <= setup_erase ? EEPC_ERASED : (setup_q & setup_data);
	end
endmodule

// file: rtl/eepc_ctrl.sv
// EEPROM program/erase control with APB register access
//
// Contract
// - Array sits at E00-FFF of selected 4K page; forced page F in single/boot.
// - Enable forced one in single/boot; test starts zero, one write enables.
// - Expanded mode: array mapped only while enable bit is one.
// - Erased byte reads FF; erase by byte, row or whole array.
// - Protect register resets all set; clearing only within 64 cycles.
// - Normal modes: bits may be set later, never cleared; special modes free.
// - Lock bits guard blocks of 32, 64, 128 and 288 bytes.
// - Setup-protect bit blocks program and erase of setup register.
// - Program/erase control register resets to zero.
// - Byte/row select choose bulk, row or byte erase.
// - Erase, latch and high-voltage bits steer the operation.
// - Latch and voltage set together before a latch-only write: neither sets.
// - Array writes ignored while high voltage on.
// - No array write between latch and voltage: no operation.
// - Bulk and row erase skip protected bytes.
// - Row erase picks row of latched address; bulk takes any address.
// - Programming only clears bits; byte/row selects ignored.
// - Setup register latched from cells at reset; test mode writes it.
// - Bulk erase of setup register also erases unprotected array.
// - Watchdog-disable bit set suppresses watchdog reset on timeout.
`timescale 1ns/100ps
module eepc_ctrl import eepc_pkg::*; #(
	parameter int UNLOCK_CYCLES = EEPC_UNLOCK_CYCLES
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [EEPC_AW-1:0] paddr,
	input wire logic [EEPC_DW-1:0] pwdata,
	output logic [EEPC_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] mode_pins,
	input wire logic watchdog_timeout,
	output logic watchdog_reset,
	output logic high_voltage_on,
	output logic op_busy
);
	typedef enum logic {ST_IDLE, ST_SWEEP} eepc_state_t;

	logic [1:0] mode_meta;
	logic [1:0] mode;
	logic [4:0] block_write_protect;
	logic [7:0] program_erase_control;
	logic [7:0] setup_latch;
	logic setup_loaded;
	logic window_open;
	eepc_pend_t pend;
	eepc_op_t op;
	logic armed;
	eepc_state_t state;
	logic [8:0] sweep_off;
	logic [8:0] sweep_end;
	logic sweep_erase;
	logic [7:0] sweep_data;
	logic [7:0] rd_data;
	logic [7:0] setup_cell;
	logic [1:0] mode_settle;
	logic [9:0] sweep_cycles;

	// Mode pins come from outside; two flops before use
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mode_meta <= EEPC_MODE_SINGLE;
			mode <= EEPC_MODE_SINGLE;
		end else begin
			mode_meta <= mode_pins;
			mode <= mode_meta;
		end
	end

	// Setup load waits until the mode pins have passed both flops
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			mode_settle <= '0;
		else
			mode_settle <= {mode_settle[0], 1'b1};
	end

	wire forced = (mode == EEPC_MODE_SINGLE) || (mode == EEPC_MODE_BOOT);
	wire special = (mode == EEPC_MODE_TEST) || (mode == EEPC_MODE_BOOT);
	wire is_test = (mode == EEPC_MODE_TEST);

	eepc_unlock #(.CYCLES(UNLOCK_CYCLES)) u_unlock (
		.core_clk(core_clk),
		.resetn(resetn),
		.window_open(window_open)
	);

	// Address decode
	wire [15:0] cpu_addr = paddr[17:2];
	wire [3:0] map_position = setup_latch[EEPC_CF_MAP +: 4];
	wire array_enable = forced ? 1'b1 : setup_latch[EEPC_CF_EN];
	wire [3:0] arr_page = forced ? EEPC_FORCED_PAGE : map_position;
	wire [8:0] arr_off = cpu_addr[8:0];
	wire hit_arr = array_enable && (cpu_addr[15:12] == arr_page) &&
		(cpu_addr[11:9] == EEPC_WIN_HI);
	wire hit_bp = (cpu_addr == EEPC_IDX_BLOCK_WRITE_PROTECT);
	wire hit_pp = (cpu_addr == EEPC_IDX_PROGRAM_ERASE_CONTROL);
	wire hit_cf = (cpu_addr == EEPC_IDX_SETUP);
	wire mapped = hit_arr || hit_bp || hit_pp || hit_cf;
	wire acc = psel && penable;
	wire wr = acc && pwrite;
	wire bp_we = wr && hit_bp;
	wire pp_we = wr && hit_pp;
	wire cf_we = wr && hit_cf;
	wire arr_we = wr && hit_arr;
	wire [7:0] wd = pwdata[7:0];

	assign pready = 1'b1;
	assign pslverr = acc && !mapped;

	// Read mux; array data comes registered from the cell module
	wire [7:0] setup_view = setup_latch | EEPC_CF_ONES;
	wire [7:0] setup_rd = {setup_view[7:1], array_enable};
	wire [7:0] rd_byte = hit_arr ? rd_data :
		hit_bp ? {3'h0, block_write_protect} :
		hit_pp ? program_erase_control :
		hit_cf ? setup_rd : 8'h00;
	assign prdata = {24'h000000, rd_byte};

	// Block protect: full write in window or special modes, else set only
	wire [4:0] next_bp = (window_open || special) ? wd[4:0] :
		(block_write_protect | wd[4:0]);
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			block_write_protect <= EEPC_BP_RESET;
		else if (bp_we)
			block_write_protect <= next_bp;
	end

	wire lat = program_erase_control[EEPC_PP_LAT];
	wire hv = program_erase_control[EEPC_PP_HV];
	wire both_early = wd[EEPC_PP_LAT] && wd[EEPC_PP_HV] && !lat;
	wire [7:0] pp_w = wd & EEPC_PP_MASK;
	wire [7:0] next_pp = both_early ?
		(pp_w & ~(8'h01 << EEPC_PP_LAT) & ~(8'h01 << EEPC_PP_HV)) : pp_w;
	wire hv_set = pp_we && !hv && next_pp[EEPC_PP_HV];
	wire hv_clear = pp_we && hv && !next_pp[EEPC_PP_HV];
	wire commit = hv_clear && armed;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			program_erase_control <= EEPC_PP_RESET;
		else if (pp_we)
			program_erase_control <= next_pp;
	end

	assign high_voltage_on = hv;

	// Latched target: captured while latch on and voltage off
	wire cap_arr = arr_we && lat && !hv;
	wire cap_cf = cf_we && lat && !hv;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			pend <= '0;
		else if (pp_we && !next_pp[EEPC_PP_LAT])
			pend <= '0;
		else if (cap_arr || cap_cf)
			pend <= '{valid: 1'b1, to_setup: cap_cf, off: arr_off, data: wd};
	end

	// Operation armed only if a target was written before voltage on
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			armed <= 1'b0;
			op <= '0;
		end else if (hv_set) begin
			armed <= pend.valid;
			op <= '{erase: next_pp[EEPC_PP_ERASE],
				byte_sel: next_pp[EEPC_PP_BYTE],
				row_sel: next_pp[EEPC_PP_ROW]};
		end else if (hv_clear) begin
			armed <= 1'b0;
		end
	end

	// Range of the committed operation
	wire bulk = op.erase && !op.byte_sel && !op.row_sel;
	wire row = op.erase && !op.byte_sel && op.row_sel;
	wire [8:0] row_base = {pend.off[8:4], 4'h0};
	wire [8:0] row_last = {pend.off[8:4], 4'hf};
	wire [8:0] start_off = bulk ? 9'h000 : row ? row_base : pend.off;
	wire [8:0] end_off = bulk ? EEPC_LAST_OFF : row ? row_last : pend.off;
	wire sweep_go = commit && (!pend.to_setup || bulk);

	// Lock bit covering an array offset
	function automatic logic [1:0] blk_of(input logic [8:0] off);
		if (off < EEPC_BLK1_START)
			blk_of = 2'd0;
		else if (off < EEPC_BLK2_START)
			blk_of = 2'd1;
		else if (off < EEPC_BLK3_START)
			blk_of = 2'd2;
		else
			blk_of = 2'd3;
	endfunction

	wire sweep_locked = block_write_protect[blk_of(sweep_off)];
	wire mem_we = (state == ST_SWEEP) && !sweep_locked;
	wire sweep_done = (sweep_off == sweep_end);

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_IDLE;
			sweep_off <= '0;
			sweep_end <= '0;
			sweep_erase <= 1'b0;
			sweep_data <= EEPC_ERASED;
		end else begin
			case (state)
				ST_IDLE: begin
					if (sweep_go) begin
						state <= ST_SWEEP;
						sweep_off <= start_off;
						sweep_end <= end_off;
						sweep_erase <= op.erase;
						sweep_data <= pend.data;
					end
				end
				ST_SWEEP: begin
					if (sweep_done)
						state <= ST_IDLE;
					else
						sweep_off <= sweep_off + 9'h001;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	assign op_busy = hv || (state == ST_SWEEP);

	// Length of the running sweep, for the length check
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			sweep_cycles <= '0;
		else if (state == ST_SWEEP)
			sweep_cycles <= sweep_cycles + 10'h001;
		else
			sweep_cycles <= '0;
	end

	// Setup cell change, blocked by setup-protect
	wire setup_we = commit && pend.to_setup &&
		!block_write_protect[EEPC_BP_SETUP];

	eepc_cells #(.DEPTH(EEPC_ARR_BYTES)) u_cells (
		.core_clk(core_clk),
		.rd_addr(arr_off),
		.rd_data(rd_data),
		.wr_en(mem_we),
		.wr_addr(sweep_off),
		.wr_erase(sweep_erase),
		.wr_data(sweep_data),
		.setup_we(setup_we),
		.setup_erase(op.erase),
		.setup_data(pend.data),
		.setup_cell(setup_cell)
	);

	// Setup register: loaded once after reset, direct writes in test only
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			setup_loaded <= 1'b0;
			setup_latch <= EEPC_CF_RESET;
		end else if (!setup_loaded && mode_settle[1]) begin
			setup_loaded <= 1'b1;
			setup_latch <= is_test ?
				(setup_cell & ~(8'h01 << EEPC_CF_EN)) : setup_cell;
		end else if (cf_we && is_test && !lat) begin
			setup_latch <= wd;
		end
	end

	assign watchdog_reset = watchdog_timeout &&
		!setup_latch[EEPC_CF_WDOFF];

	// Checks
	chk_bp_noclear: assert property (@(posedge core_clk) disable iff (!resetn)
		(!special && !window_open && bp_we) |=>
		((block_write_protect & $past(block_write_protect)) ==
		$past(block_write_protect)))
		else $error("protect bit cleared after unlock window");
	chk_both_early: assert property (@(posedge core_clk) disable iff (!resetn)
		(pp_we && !lat && wd[EEPC_PP_LAT] && wd[EEPC_PP_HV]) |=>
		(!lat && !hv))
		else $error("latch and voltage set in one early write");
	chk_hv_ignore: assert property (@(posedge core_clk) disable iff (!resetn)
		(arr_we && hv && !pp_we) |=> $stable(pend))
		else $error("array write disturbed operation");
	chk_no_target: assert property (@(posedge core_clk) disable iff (!resetn)
		(hv_set && !pend.valid) |=> (!armed ##1 (state == ST_IDLE)))
		else $error("operation armed with no target");
	chk_lock_block: assert property (@(posedge core_clk) disable iff (!resetn)
		mem_we |-> !(
		(sweep_off < EEPC_BLK1_START) ? block_write_protect[0] :
		(sweep_off < EEPC_BLK2_START) ? block_write_protect[1] :
		(sweep_off < EEPC_BLK3_START) ? block_write_protect[2] :
		block_write_protect[3]))
		else $error("write into locked block");
	chk_setup_prot: assert property (@(posedge core_clk) disable iff (!resetn)
		(commit && pend.to_setup && block_write_protect[EEPC_BP_SETUP]) |=>
		$stable(setup_cell))
		else $error("protected setup cell changed");
	chk_page_force: assert property (@(posedge core_clk) disable iff (!resetn)
		(forced && psel && cpu_addr[15:9] == {EEPC_FORCED_PAGE, EEPC_WIN_HI})
		|-> hit_arr)
		else $error("array not at forced page");
	chk_map_off: assert property (@(posedge core_clk) disable iff (!resetn)
		(mode == EEPC_MODE_EXP && !setup_latch[EEPC_CF_EN]) |-> !hit_arr)
		else $error("disabled array still decoded");
	chk_row_len: assert property (@(posedge core_clk) disable iff (!resetn)
		(sweep_go && row && !pend.to_setup) |=> ##15
		(state == ST_SWEEP && sweep_done &&
		sweep_cycles == 10'(EEPC_ROW_BYTES - 1)) ##1 (state == ST_IDLE))
		else $error("row erase length wrong");
	chk_test_load: assert property (@(posedge core_clk) disable iff (!resetn)
		(!setup_loaded && mode_settle[1] && is_test) |=>
		!setup_latch[EEPC_CF_EN])
		else $error("enable not cleared at test-mode load");
	chk_wdog: assert property (@(posedge core_clk) disable iff (!resetn)
		(watchdog_timeout && setup_loaded) |->
		(watchdog_reset != setup_rd[EEPC_CF_WDOFF]))
		else $error("watchdog reset against disable bit");

	cov_program: cover property (@(posedge core_clk) disable iff (!resetn)
		commit && !op.erase);
	cov_bulk: cover property (@(posedge core_clk) disable iff (!resetn)
		sweep_go && bulk);
	cov_early_both: cover property (@(posedge core_clk) disable iff (!resetn)
		pp_we && both_early);
	cov_row: cover property (@(posedge core_clk) disable iff (!resetn)
		sweep_go && row);
	cov_setup_prog: cover property (@(posedge core_clk) disable iff (!resetn)
		setup_we && !op.erase);
endmodule

// file: rtl/eepc_pkg.sv
// Shared constants and types for the EEPROM program/erase control block
package eepc_pkg;
	localparam int EEPC_AW = 18;
	localparam int EEPC_DW = 32;
	// Register indexes; the byte address is four times the index
	localparam logic [15:0] EEPC_IDX_BLOCK_WRITE_PROTECT = 16'h1035;
	localparam logic [15:0] EEPC_IDX_PROGRAM_ERASE_CONTROL = 16'h103b;
	localparam logic [15:0] EEPC_IDX_SETUP = 16'h103f;
	// Array window inside a 4K page
	localparam logic [2:0] EEPC_WIN_HI = 3'h7;
	localparam logic [3:0] EEPC_FORCED_PAGE = 4'hf;
	localparam int EEPC_ARR_BYTES = 512;
	localparam int EEPC_ROW_BYTES = 16;
	// Block boundaries (array offsets)
	localparam logic [8:0] EEPC_BLK1_START = 9'h020;
	localparam logic [8:0] EEPC_BLK2_START = 9'h060;
	localparam logic [8:0] EEPC_BLK3_START = 9'h0e0;
	localparam logic [8:0] EEPC_LAST_OFF = 9'h1ff;
	// Block-protect fields and reset
	localparam int EEPC_BP_SETUP = 4;
	localparam logic [4:0] EEPC_BP_RESET = 5'h1f;
	// Program/erase control fields
	localparam int EEPC_PP_ODD = 7;
	localparam int EEPC_PP_EVEN = 6;
	localparam int EEPC_PP_BYTE = 4;
	localparam int EEPC_PP_ROW = 3;
	localparam int EEPC_PP_ERASE = 2;
	localparam int EEPC_PP_LAT = 1;
	localparam int EEPC_PP_HV = 0;
	localparam logic [7:0] EEPC_PP_RESET = 8'h00;
	localparam logic [7:0] EEPC_PP_MASK = 8'hdf;
	// Setup register fields
	localparam int EEPC_CF_MAP = 4;
	localparam int EEPC_CF_WDOFF = 2;
	localparam int EEPC_CF_EN = 0;
	localparam logic [7:0] EEPC_CF_ONES = 8'h0a;
	localparam logic [7:0] EEPC_CF_RESET = 8'h0a;
	localparam logic [7:0] EEPC_ERASED = 8'hff;
	localparam int EEPC_UNLOCK_CYCLES = 64;
	// Operating mode codes on the mode pins
	localparam logic [1:0] EEPC_MODE_BOOT = 2'h0;
	localparam logic [1:0] EEPC_MODE_SINGLE = 2'h1;
	localparam logic [1:0] EEPC_MODE_TEST = 2'h2;
	localparam logic [1:0] EEPC_MODE_EXP = 2'h3;

	typedef struct packed {
		logic valid;
		logic to_setup;
		logic [8:0] off;
		logic [7:0] data;
	} eepc_pend_t;

	typedef struct packed {
		logic erase;
		logic byte_sel;
		logic row_sel;
	} eepc_op_t;
endpackage

// file: rtl/eepc_unlock.sv
// Unlock window timer counting bus-clock cycles after reset
`timescale 1ns/100ps
module eepc_unlock import eepc_pkg::*; #(
	parameter int CYCLES = EEPC_UNLOCK_CYCLES
) (
	input wire logic core_clk,
	input wire logic resetn,
	output logic window_open
);
	logic [$clog2(CYCLES+1)-1:0] count;
	localparam logic [$clog2(CYCLES+1)-1:0] LAST = CYCLES[$clog2(CYCLES+1)-1:0];

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			count <= '0;
		else if (count != LAST)
			count <= count + 1'b1;
	end

	assign window_open = (count != LAST);
endmodule

// file: sim/tb_eeprom_program_erase_control.sv
// Self-checking bench for the EEPROM program/erase control block
`timescale 1ns/100ps
module tb_eeprom_program_erase_control import eepc_pkg::*;;
	localparam int UNLOCK = 16;
	localparam int HV_HOLD = 8;
	localparam logic [17:0] A_BP = {EEPC_IDX_BLOCK_WRITE_PROTECT, 2'b00};
	localparam logic [17:0] A_PP = {EEPC_IDX_PROGRAM_ERASE_CONTROL, 2'b00};
	localparam logic [17:0] A_CF = {EEPC_IDX_SETUP, 2'b00};
	localparam logic [32:0] ERR = {1'b1, 32'h0};

	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [EEPC_AW-1:0] paddr = '0;
	logic [EEPC_DW-1:0] pwdata = '0;
	logic [EEPC_DW-1:0] prdata;
	logic pready;
	logic pslverr;
	logic [1:0] mode_pins = EEPC_MODE_SINGLE;
	logic watchdog_timeout = 1'b0;
	logic watchdog_reset;
	logic high_voltage_on;
	logic op_busy;
	int mismatches = 0;
	int comparisons = 0;
	logic [32:0] exp_q[$];

	eepc_ctrl #(.UNLOCK_CYCLES(UNLOCK)) u_dut (
		.core_clk(core_clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mode_pins(mode_pins),
		.watchdog_timeout(watchdog_timeout),
		.watchdog_reset(watchdog_reset),
		.high_voltage_on(high_voltage_on), .op_busy(op_busy)
	);

	always #20 core_clk = ~core_clk;

	task automatic test_done;
		if (mismatches == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	function automatic logic [32:0] ok(input logic [7:0] v);
		return {1'b0, 24'h0, v};
	endfunction

	// Byte address of an array offset in the page at base
	function automatic logic [17:0] ea(input logic [15:0] base,
		input logic [8:0] off);
		return {base | {7'h0, off}, 2'b00};
	endfunction

	task automatic xfer(input logic w, input logic [17:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			test_done();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [17:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [17:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		xfer(1'b0, a, 8'h00);
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		repeat (2) @(posedge core_clk);
		while (op_busy !== 1'b0 && n < 2000) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 2000) begin
			mismatches++;
			test_done();
		end
	endtask

	// Full latch / voltage sequence; stray write lands while voltage is on
	task automatic pe(input logic [7:0] ctl, input logic [17:0] a,
		input logic [7:0] d, input logic stray);
		wr(A_PP, ctl);
		wr(a, d);
		wr(A_PP, ctl | 8'h01);
		repeat (HV_HOLD) @(posedge core_clk);
		check({32'h0, high_voltage_on}, 33'h1);
		if (stray) begin
			wr(a, ~d);
		end
		wr(A_PP, ctl);
		wait_idle();
		wr(A_PP, 8'h00);
	endtask

	task automatic do_reset;
		resetn <= 1'b0;
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge core_clk);
	endtask

	// Read results are matched against the oldest note
	always @(posedge core_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (exp_q.size() > 0) begin
				check({pslverr, prdata}, exp_q.pop_front());
			end else begin
				check({pslverr, prdata}, {33{1'bx}});
			end
		end
	end

	initial begin
		logic [7:0] d1;
		logic [7:0] d2;
		void'($urandom(97));
		d1 = 8'($urandom);
		d2 = 8'($urandom);
		do_reset();
		rd(A_BP, ok(8'h1f));
		wr(A_BP, 8'h00);
		rd(A_PP, ok(8'h00));
		rd(A_CF, ok(8'hff));
		rd(A_BP, ok(8'h00));
		watchdog_timeout <= 1'b1;
		repeat (UNLOCK) @(posedge core_clk);
		check({32'h0, watchdog_reset}, 33'h0);
		wr(A_BP, 8'h01);
		wr(A_BP, 8'h00);
		rd(A_BP, ok(8'h01));
		pe(8'h02, ea(16'hfe00, 9'h020), d1, 1'b1);
		rd(ea(16'hfe00, 9'h020), ok(d1));
		pe(8'h1a, ea(16'hfe00, 9'h020), d2, 1'b1);
		rd(ea(16'hfe00, 9'h020), ok(d1 & d2));
		wr(A_PP, 8'h03);
		rd(A_PP, ok(8'h00));
		wr(ea(16'hfe00, 9'h020), 8'h00);
		wr(A_PP, 8'h02);
		wr(A_PP, 8'h03);
		wr(A_PP, 8'h02);
		wait_idle();
		wr(A_PP, 8'h00);
		rd(ea(16'hfe00, 9'h020), ok(d1 & d2));
		pe(8'h16, ea(16'hfe00, 9'h020), 8'h00, 1'b1);
		rd(ea(16'hfe00, 9'h020), ok(EEPC_ERASED));
		pe(8'h02, ea(16'hfe00, 9'h030), 8'h00, 1'b0);
		pe(8'h02, ea(16'hfe00, 9'h03f), 8'h00, 1'b0);
		pe(8'h02, ea(16'hfe00, 9'h040), 8'h00, 1'b0);
		pe(8'h0e, ea(16'hfe00, 9'h035), 8'h00, 1'b1);
		rd(ea(16'hfe00, 9'h030), ok(8'hff));
		rd(ea(16'hfe00, 9'h03f), ok(8'hff));
		rd(ea(16'hfe00, 9'h040), ok(8'h00));
		mode_pins <= EEPC_MODE_BOOT;
		repeat (3) @(posedge core_clk);
		wr(A_BP, 8'h00);
		wr(A_BP, 8'h02);
		rd(A_BP, ok(8'h02));
		pe(8'h02, ea(16'hfe00, 9'h01f), 8'h00, 1'b0);
		pe(8'h02, ea(16'hfe00, 9'h020), 8'h00, 1'b0);
		pe(8'h02, ea(16'hfe00, 9'h1ff), 8'h00, 1'b0);
		rd(ea(16'hfe00, 9'h01f), ok(8'h00));
		rd(ea(16'hfe00, 9'h020), ok(8'hff));
		pe(8'h06, ea(16'hfe00, 9'h100), 8'h00, 1'b1);
		rd(ea(16'hfe00, 9'h01f), ok(8'hff));
		rd(ea(16'hfe00, 9'h040), ok(8'h00));
		rd(ea(16'hfe00, 9'h1ff), ok(8'hff));
		wr(A_BP, 8'h12);
		pe(8'h02, A_CF, 8'hfe, 1'b0);
		wr(A_BP, 8'h02);
		pe(8'h02, A_CF, 8'hfb, 1'b0);
		rd(A_CF, ok(8'hff));
		do_reset();
		rd(A_CF, ok(8'hfb));
		check({32'h0, watchdog_reset}, 33'h1);
		wr(A_BP, 8'h02);
		pe(8'h02, ea(16'hfe00, 9'h1ff), 8'h00, 1'b0);
		pe(8'h06, A_CF, 8'h00, 1'b0);
		rd(ea(16'hfe00, 9'h1ff), ok(8'hff));
		rd(ea(16'hfe00, 9'h040), ok(8'h00));
		mode_pins <= EEPC_MODE_TEST;
		do_reset();
		rd(A_CF, ok(8'hfe));
		rd(ea(16'hfe00, 9'h040), ERR);
		wr(A_CF, 8'h7b);
		rd(A_CF, ok(8'h7b));
		rd(ea(16'h7e00, 9'h040), ok(8'h00));
		rd(ea(16'hfe00, 9'h040), ERR);
		wr(A_BP, 8'h00);
		pe(8'h02, A_CF, 8'h7a, 1'b0);
		mode_pins <= EEPC_MODE_EXP;
		repeat (3) @(posedge core_clk);
		rd(ea(16'h7e00, 9'h040), ok(8'h00));
		do_reset();
		rd(A_CF, ok(8'h7a));
		rd(ea(16'h7e00, 9'h040), ERR);
		repeat (3) @(posedge core_clk);
		if (exp_q.size() != 0) begin
			mismatches++;
		end
		test_done();
	end
endmodule
